/* hw/awdrp_port.sv */
// Write data and write response port block with an APB register window.
// Assumes upstream master on the _s side, downstream slave on the _m side,
// one clock pclk and APB master sync to it.
//
// Overview of operation
// [R1] ID width 0-16 slave side, 1-24 master side
// [R2] Write data ID exists only under AXI3
// [R3] Data width is 32, 64, 128 or 256
// [R4] High strobe marks its byte lane valid
// [R5] One strobe per byte, bit n covers 8n..8n+7
// [R6] User sideband width 0-256, zero removes it
// [R7] Slave-facing ports end _s, master-facing _m
// [R8] Beats move only when valid and ready high
//
// Design decisions made here: the address map and the APB slave port.

////////////////////////////////////////////////////////////////////////////////

module awdrp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_idx;
  logic [PW-1:0] rd_idx;
  logic [LW-1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [PW-1:0] next_wr_idx = (wr_idx == LAST_IDX) ? '0 : PW'(wr_idx + 1'b1);
  wire [PW-1:0] next_rd_idx = (rd_idx == LAST_IDX) ? '0 : PW'(rd_idx + 1'b1);

  // Full stops intake, so back-pressure reaches the source
  assign in_ready = (count != LW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_idx];
  assign level = count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end else begin
      if (push) wr_idx <= next_wr_idx;
      if (pop) rd_idx <= next_rd_idx;
      if (push && !pop) count <= LW'(count + 1'b1);
      else if (pop && !push) count <= LW'(count - 1'b1);
    end
  end

  // Payload storage needs no reset; valid gates it
  always_ff @(posedge pclk) begin
    if (push) mem[wr_idx] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module awdrp_port #(
  parameter int ID_WIDTH = awdrp_pkg::DEF_ID_WIDTH,
  parameter int DATA_WIDTH = awdrp_pkg::DEF_DATA_WIDTH,
  parameter int USER_WIDTH = awdrp_pkg::DEF_USER_WIDTH,
  parameter bit AXI3 = 1'b1,
  parameter bit MASTER_SIDE = 1'b0,
  parameter int FIFO_DEPTH = awdrp_pkg::DEF_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB register window
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Write data from upstream master
  input wire logic [((ID_WIDTH > 0) ? ID_WIDTH : 1)-1:0] wid_s, // see [R7]
  input wire logic [DATA_WIDTH-1:0] wdata_s,
  input wire logic [DATA_WIDTH/awdrp_pkg::LANE_BITS-1:0] wstrb_s,
  input wire logic wlast_s,
  input wire logic [((USER_WIDTH > 0) ? USER_WIDTH : 1)-1:0] wuser_s,
  input wire logic wvalid_s,
  output logic wready_s,
  // Write response to upstream master
  output logic [((ID_WIDTH > 0) ? ID_WIDTH : 1)-1:0] bid_s,
  output logic [1:0] bresp_s,
  output logic [((USER_WIDTH > 0) ? USER_WIDTH : 1)-1:0] buser_s,
  output logic bvalid_s,
  input wire logic bready_s,
  // Write data to downstream slave
  output logic [((ID_WIDTH > 0) ? ID_WIDTH : 1)-1:0] wid_m, // see [R7]
  output logic [DATA_WIDTH-1:0] wdata_m,
  output logic [DATA_WIDTH/awdrp_pkg::LANE_BITS-1:0] wstrb_m,
  output logic wlast_m,
  output logic [((USER_WIDTH > 0) ? USER_WIDTH : 1)-1:0] wuser_m,
  output logic wvalid_m,
  input wire logic wready_m,
  // Write response from downstream slave
  input wire logic [((ID_WIDTH > 0) ? ID_WIDTH : 1)-1:0] bid_m,
  input wire logic [1:0] bresp_m,
  input wire logic [((USER_WIDTH > 0) ? USER_WIDTH : 1)-1:0] buser_m,
  input wire logic bvalid_m,
  output logic bready_m
);
  import awdrp_pkg::*;

  // Zero widths keep a one-bit port that is tied off and ignored
  localparam int IDW = (ID_WIDTH > 0) ? ID_WIDTH : 1; // see [R1]
  localparam int USW = (USER_WIDTH > 0) ? USER_WIDTH : 1; // see [R6]
  localparam int SW = DATA_WIDTH / LANE_BITS; // see [R5]
  localparam int EW = IDW + USW + SW + 1 + DATA_WIDTH;
  localparam int LW = $clog2(FIFO_DEPTH + 1);
  localparam bit HAS_ID = (ID_WIDTH > 0);
  localparam bit HAS_WID = AXI3 && HAS_ID; // see [R2]
  localparam bit HAS_USER = (USER_WIDTH > 0); // see [R6]
  localparam bit ID_OK = MASTER_SIDE ? (ID_WIDTH >= 1 && ID_WIDTH <= MSIDE_ID_MAX)
                                     : (ID_WIDTH >= 0 && ID_WIDTH <= SSIDE_ID_MAX); // see [R1]
  localparam bit USER_OK = (USER_WIDTH >= 0) && (USER_WIDTH <= USER_MAX); // see [R6]
  localparam bit CFG_OK = ID_OK && USER_OK && awdrp_data_width_ok(DATA_WIDTH); // see [R3]

  ////////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [31:0] ctrl;
  logic flag_nostrb;
  logic flag_errresp;
  logic [31:0] beat_count;
  logic [31:0] burst_count;
  logic [31:0] resp_count;
  logic [31:0] prdata_q;
  logic pslverr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Write data path

  wire ctrl_en = ctrl[CTRL_EN_BIT];
  wire ctrl_mask = ctrl[CTRL_MASK_BIT];
  logic [DATA_WIDTH-1:0] masked_data;
  logic fifo_in_ready;
  logic [EW-1:0] fifo_out;
  logic [LW-1:0] fifo_level;

  // Lanes with a low strobe carry nothing; masking zeroes them on request
  for (genvar i = 0; i < SW; i++) begin : g_lane
    assign masked_data[LANE_BITS*i +: LANE_BITS] =
      (ctrl_mask && !wstrb_s[i]) ? 8'h00 : wdata_s[LANE_BITS*i +: LANE_BITS]; // see [R4] see [R5]
  end

  wire [IDW-1:0] in_id = HAS_WID ? wid_s : '0; // see [R2]
  wire [USW-1:0] in_user = HAS_USER ? wuser_s : '0; // see [R6]
  wire [EW-1:0] fifo_in = {in_id, in_user, wstrb_s, wlast_s, masked_data};

  // Disabling stops intake only; queued beats still drain
  wire fifo_in_valid = wvalid_s && ctrl_en;
  assign wready_s = fifo_in_ready && ctrl_en;
  wire w_accept = wvalid_s && wready_s; // see [R8]

  awdrp_fifo #(
    .WIDTH(EW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(wvalid_m), // see [R8]
    .out_ready(wready_m),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  // Unpack the head entry onto the master-facing ports
  assign wdata_m = fifo_out[DATA_WIDTH-1:0]; // see [R3]
  assign wlast_m = fifo_out[DATA_WIDTH];
  assign wstrb_m = fifo_out[DATA_WIDTH+1 +: SW];
  assign wuser_m = fifo_out[DATA_WIDTH+1+SW +: USW];
  assign wid_m = fifo_out[EW-1 -: IDW];

  ////////////////////////////////////////////////////////////////////////////////
  // Write response path, one register stage

  // Stage accepts when empty or being emptied this cycle
  assign bready_m = !bvalid_s || bready_s; // see [R8]
  wire b_in = bvalid_m && bready_m;
  wire b_out = bvalid_s && bready_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bvalid_s <= 1'b0;
      bid_s <= '0;
      bresp_s <= BRESP_OKAY;
      buser_s <= '0;
    end else if (bready_m) begin
      bvalid_s <= bvalid_m;
      if (bvalid_m) begin
        bid_s <= HAS_ID ? bid_m : '0; // see [R1]
        bresp_s <= bresp_m;
        buser_s <= HAS_USER ? buser_m : '0; // see [R6]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire hit_ctrl = (paddr == REG_CTRL);
  wire hit_status = (paddr == REG_STATUS);
  wire hit_beats = (paddr == REG_BEATS);
  wire hit_bursts = (paddr == REG_BURSTS);
  wire hit_resps = (paddr == REG_RESPS);
  wire hit_config = (paddr == REG_CONFIG);
  wire hit_any = hit_ctrl || hit_status || hit_beats || hit_bursts || hit_resps || hit_config;

  // Status word from live FIFO state and sticky flags
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[ST_LEVEL_LSB +: ST_LEVEL_W] = ST_LEVEL_W'(fifo_level);
    status_word[ST_FULL_BIT] = !fifo_in_ready;
    status_word[ST_EMPTY_BIT] = !wvalid_m;
    status_word[ST_NOSTRB_BIT] = flag_nostrb;
    status_word[ST_ERRRESP_BIT] = flag_errresp;
  end

  logic [31:0] config_word;
  always_comb begin
    config_word = '0;
    config_word[CFG_ID_LSB +: 5] = 5'(ID_WIDTH);
    config_word[CFG_DATA_LSB +: 9] = 9'(DATA_WIDTH);
    config_word[CFG_USER_LSB +: 9] = 9'(USER_WIDTH);
    config_word[CFG_MSIDE_BIT] = MASTER_SIDE;
    config_word[CFG_OK_BIT] = CFG_OK;
    config_word[CFG_AXI3_BIT] = AXI3;
  end

  wire [31:0] read_mux = hit_ctrl ? ctrl :
                         hit_status ? status_word :
                         hit_beats ? beat_count :
                         hit_bursts ? burst_count :
                         hit_resps ? resp_count :
                         hit_config ? config_word : 32'h0000_0000;

  // Read data captured in the setup cycle, so the bus sees a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : read_mux;
      pslverr_q <= !hit_any;
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Control, flags and counters

  wire set_nostrb = w_accept && (wstrb_s == '0); // see [R4]
  wire set_errresp = b_in && (bresp_m != BRESP_OKAY);
  wire clr_nostrb = apb_wr && hit_status && pwdata[ST_NOSTRB_BIT];
  wire clr_errresp = apb_wr && hit_status && pwdata[ST_ERRRESP_BIT];
  wire burst_done = w_accept && wlast_s;

  // A clearing write restarts a counter; an event in that cycle still counts
  wire [31:0] next_beat_count = (apb_wr && hit_beats) ? 32'(w_accept) : beat_count + 32'(w_accept);
  wire [31:0] next_burst_count = (apb_wr && hit_bursts) ? 32'(burst_done) : burst_count + 32'(burst_done);
  wire [31:0] next_resp_count = (apb_wr && hit_resps) ? 32'(b_out) : resp_count + 32'(b_out);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      flag_nostrb <= 1'b0;
      flag_errresp <= 1'b0;
      beat_count <= '0;
      burst_count <= '0;
      resp_count <= '0;
    end else begin
      if (apb_wr && hit_ctrl) ctrl <= {30'h0, pwdata[CTRL_MASK_BIT], pwdata[CTRL_EN_BIT]};
      flag_nostrb <= (flag_nostrb && !clr_nostrb) || set_nostrb;
      flag_errresp <= (flag_errresp && !clr_errresp) || set_errresp;
      beat_count <= next_beat_count;
      burst_count <= next_burst_count;
      resp_count <= next_resp_count;
    end
  end
endmodule

/* pkg/awdrp_pkg.sv */
// Package for the write data and write response port block.
// Assumes one APB slave window of 32-bit aligned registers.
package awdrp_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BEATS = 8'h08;
  localparam logic [7:0] REG_BURSTS = 8'h0C;
  localparam logic [7:0] REG_RESPS = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h14;

  // Control fields and reset value
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MASK_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Status fields
  localparam int ST_LEVEL_LSB = 0;
  localparam int ST_LEVEL_W = 8;
  localparam int ST_FULL_BIT = 8;
  localparam int ST_EMPTY_BIT = 9;
  localparam int ST_NOSTRB_BIT = 16;
  localparam int ST_ERRRESP_BIT = 17;

  // Configuration fields
  localparam int CFG_ID_LSB = 0;
  localparam int CFG_DATA_LSB = 8;
  localparam int CFG_USER_LSB = 18;
  localparam int CFG_MSIDE_BIT = 29;
  localparam int CFG_OK_BIT = 30;
  localparam int CFG_AXI3_BIT = 31;

  // Port defaults and legal ranges
  localparam int DEF_ID_WIDTH = 4;
  localparam int DEF_DATA_WIDTH = 32;
  localparam int DEF_USER_WIDTH = 0;
  localparam int DEF_FIFO_DEPTH = 8;
  localparam int SSIDE_ID_MAX = 16;
  localparam int MSIDE_ID_MAX = 24;
  localparam int USER_MAX = 256;
  localparam int LANE_BITS = 8;
  localparam logic [1:0] BRESP_OKAY = 2'h0;

  // True for the four allowed data bus widths
  function automatic bit awdrp_data_width_ok(input int w);
    return (w == 32) || (w == 64) || (w == 128) || (w == 256);
  endfunction

endpackage

/* dv/awdrp_assertions.sv */
// Port checker for the write data and response block.
// Assumes one clock pclk and active-low presetn.
module awdrp_assertions import awdrp_pkg::*; #(
  parameter int ID_WIDTH = DEF_ID_WIDTH,
  parameter int DATA_WIDTH = DEF_DATA_WIDTH,
  parameter int USER_WIDTH = DEF_USER_WIDTH,
  parameter bit AXI3 = 1'b1
) (
  // Clock, reset, APB
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  // Write data
  input wire logic wvalid_s, wready_s, wvalid_m, wready_m,
  input wire logic [DATA_WIDTH-1:0] wdata_m,
  input wire logic [DATA_WIDTH/8-1:0] wstrb_m,
  // Write response
  input wire logic bvalid_m, bready_m, bvalid_s, bready_s,
  input wire logic [((ID_WIDTH > 0) ? ID_WIDTH : 1)-1:0] bid_m, bid_s,
  input wire logic [1:0] bresp_m, bresp_s
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic cfg_rd = psel && penable && !pwrite && paddr == REG_CONFIG;
  ////////////////////////////////////////////////////////////////////////////
  a_wm_hold: assert property (wvalid_m && !wready_m |=> wvalid_m && $stable(wdata_m) && $stable(wstrb_m))
    else $error("w beat dropped or changed");
  a_bs_hold: assert property (bvalid_s && !bready_s |=> bvalid_s && $stable(bid_s) && $stable(bresp_s))
    else $error("b response dropped or changed");
  a_w_moves_out: assert property (wvalid_s && wready_s |=> wvalid_m)
    else $error("accepted beat not offered");
  a_b_passes_up: assert property (bvalid_m && bready_m |=> bvalid_s && bid_s == $past(bid_m) && bresp_s == $past(bresp_m))
    else $error("response not passed up");
  a_b_ready_rule: assert property (bready_m == (!bvalid_s || bready_s))
    else $error("bready_m wrong");
  a_cfg_id_width: assert property (cfg_rd |-> prdata[4:0] == 5'(ID_WIDTH))
    else $error("config id width");
  a_cfg_data_width: assert property (cfg_rd |-> prdata[16:8] == 9'(DATA_WIDTH) && prdata[30])
    else $error("config data width");
  a_cfg_user_width: assert property (cfg_rd |-> prdata[26:18] == 9'(USER_WIDTH))
    else $error("config user width");
  a_cfg_axi3_flag: assert property (cfg_rd |-> prdata[31] == AXI3)
    else $error("config axi3 flag");
  a_apb_no_wait: assert property (psel |-> pready)
    else $error("pready low");
  c_w_stall: cover property (wvalid_m && !wready_m);
  c_b_stall: cover property (bvalid_s && !bready_s);
  c_w_full: cover property (wvalid_s && !wready_s);
  c_apb_err: cover property (penable && pslverr);
endmodule

bind awdrp_port awdrp_assertions #(.ID_WIDTH(ID_WIDTH), .DATA_WIDTH(DATA_WIDTH), .USER_WIDTH(USER_WIDTH), .AXI3(AXI3))
  u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .paddr(paddr), .prdata(prdata), .wvalid_s(wvalid_s), .wready_s(wready_s),
  .wvalid_m(wvalid_m), .wready_m(wready_m), .wdata_m(wdata_m), .wstrb_m(wstrb_m), .bvalid_m(bvalid_m),
  .bready_m(bready_m), .bvalid_s(bvalid_s), .bready_s(bready_s), .bid_m(bid_m), .bid_s(bid_s),
  .bresp_m(bresp_m), .bresp_s(bresp_s));

/* dv/awdrp_far_slave.sv */
// Downstream slave model: takes beats, answers each burst.
// Assumes the bench steers stall and error through inputs.
module awdrp_far_slave #(
  parameter int IDW = 4,
  parameter int DW = 32
) (
  // Clock, reset, steering
  input wire logic pclk, presetn, stall, bad,
  // Write data
  input wire logic [IDW-1:0] wid_m,
  input wire logic [DW-1:0] wdata_m,
  input wire logic [DW/8-1:0] wstrb_m,
  input wire logic wlast_m, wvalid_m,
  output logic wready_m,
  // Write response
  output logic [IDW-1:0] bid_m,
  output logic [1:0] bresp_m,
  output logic buser_m, bvalid_m,
  input wire logic bready_m
);
  logic [DW+DW/8:0] got[$];
  logic [IDW+1:0] pend[$];
  assign wready_m = !stall;
  assign buser_m = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bvalid_m <= 1'b0;
      bid_m <= '0;
      bresp_m <= 2'h0;
    end else begin
      if (wvalid_m && wready_m) begin
        got.push_back({wlast_m, wstrb_m, wdata_m});
        if (wlast_m) pend.push_back({wid_m, bad ? 2'h2 : 2'h0});
      end
      if (!bvalid_m || bready_m) begin
        if (pend.size() > 0) begin
          {bid_m, bresp_m} <= pend.pop_front();
          bvalid_m <= 1'b1;
        end else begin
          // Released fields toggle so stale values never look valid
          bvalid_m <= 1'b0;
          bid_m <= ~bid_m;
          bresp_m <= ~bresp_m;
        end
      end
    end
  end
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the write data and response block.
// Assumes default parameters: 4-bit ID, 32-bit data, no user bits.
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; $display("Error %s exp %0h got %0h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import awdrp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, wdata_s = 32'h0, rd;
  logic [3:0] wid_s = 4'h0, wstrb_s = 4'h0;
  logic wlast_s = 0, wvalid_s = 0, bready_s = 1, stall = 0, bad = 0;
  wire logic pready, pslverr, wready_s, bvalid_s, wlast_m, wvalid_m, wready_m, bvalid_m, bready_m;
  wire logic buser_s, wuser_m, buser_m;
  wire logic [31:0] prdata, wdata_m;
  wire logic [3:0] bid_s, wid_m, bid_m, wstrb_m;
  wire logic [1:0] bresp_s, bresp_m;
  logic [5:0] resp_q[$];
  int miscompares = 0, num_checks = 0;
  always #50 pclk = ~pclk;
  // Upstream ports end _s, downstream _m
  awdrp_port dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .wid_s(wid_s), .wdata_s(wdata_s),
    .wstrb_s(wstrb_s), .wlast_s(wlast_s), .wuser_s(1'b0), .wvalid_s(wvalid_s), .wready_s(wready_s), .bid_s(bid_s),
    .bresp_s(bresp_s), .buser_s(buser_s), .bvalid_s(bvalid_s), .bready_s(bready_s), .wid_m(wid_m),
    .wdata_m(wdata_m), .wstrb_m(wstrb_m), .wlast_m(wlast_m), .wuser_m(wuser_m), .wvalid_m(wvalid_m),
    .wready_m(wready_m), .bid_m(bid_m), .bresp_m(bresp_m), .buser_m(buser_m), .bvalid_m(bvalid_m), .bready_m(bready_m));
  awdrp_far_slave far (.pclk(pclk), .presetn(presetn), .stall(stall), .bad(bad), .wid_m(wid_m), .wdata_m(wdata_m),
    .wstrb_m(wstrb_m), .wlast_m(wlast_m), .wvalid_m(wvalid_m), .wready_m(wready_m), .bid_m(bid_m),
    .bresp_m(bresp_m), .buser_m(buser_m), .bvalid_m(bvalid_m), .bready_m(bready_m));
  always @(posedge pclk) if (presetn && bvalid_s && bready_s) resp_q.push_back({bid_s, bresp_s});
  ////////////////////////////////////////////////////////////////////////////
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Valid stays high across a burst, so back-to-back beats never glitch
  task send(input int n, input logic [3:0] id, input logic [31:0] d0, input logic [3:0] s);
    for (int i = 0; i < n; i++) begin
      wid_s <= id;
      wdata_s <= d0 + i;
      wstrb_s <= s;
      wlast_s <= (i == n - 1);
      wvalid_s <= 1'b1;
      do @(posedge pclk); while (!wready_s);
    end
    wvalid_s <= 1'b0;
    wdata_s <= ~wdata_s;
  endtask
  task wait_got(input int n);
    repeat (40) if (far.got.size() < n) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    apb(1'b1, REG_CONFIG, 32'h0);
    apb(1'b0, REG_CONFIG, 32'h0);
    `CHK("config", 32'hC000_2004, rd)
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl reset", CTRL_RESET, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped err", 1'b1, er)
  endtask
  task t_flow;
    stall <= 1'b1;
    send(8, 4'h3, 32'h1000_0000, 4'hF);
    @(posedge pclk);
    `CHK("wready full", 1'b0, wready_s)
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK("status full", 32'h0000_0108, rd)
    stall <= 1'b0;
    wait_got(8);
    for (int i = 0; i < 8; i++) `CHK("beat", {i == 7, 4'hF, 32'h1000_0000 + i}, far.got[i])
    apb(1'b0, REG_BURSTS, 32'h0);
    `CHK("bursts", 32'h1, rd)
    `CHK("response", {4'h3, 2'h0}, resp_q[0])
  endtask
  task t_mask;
    apb(1'b1, REG_CTRL, 32'h3);
    bad <= 1'b1;
    bready_s <= 1'b0;
    send(1, 4'hA, 32'hFFFF_FFFF, 4'h5);
    wait_got(9);
    `CHK("masked beat", {1'b1, 4'h5, 32'h00FF_00FF}, far.got[8])
    repeat (4) @(posedge pclk);
    `CHK("held valid", 1'b1, bvalid_s)
    `CHK("held bid", 4'hA, bid_s)
    `CHK("held bresp", 2'h2, bresp_s)
    bready_s <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK("err sticky", 32'h0002_0200, rd)
  endtask
  // Sticky clear, zero-strobe flag, counters, intake disable, tied-off user bits
  task t_ctl;
    bad <= 1'b0;
    apb(1'b1, REG_STATUS, 32'h0003_0000);
    send(1, 4'h5, 32'hA5A5_A5A5, 4'h0);
    wait_got(10);
    `CHK("zero strobe beat", {1'b1, 4'h0, 32'h0}, far.got[9])
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK("nostrb sticky", 32'h0001_0200, rd)
    apb(1'b0, REG_BEATS, 32'h0);
    `CHK("beats", 32'hA, rd)
    apb(1'b0, REG_RESPS, 32'h0);
    `CHK("resps", 32'h3, rd)
    apb(1'b1, REG_BEATS, 32'h0);
    apb(1'b0, REG_BEATS, 32'h0);
    `CHK("beats cleared", 32'h0, rd)
    apb(1'b1, REG_CTRL, 32'h0);
    @(posedge pclk);
    `CHK("wready off", 1'b0, wready_s)
    `CHK("wuser tied", 1'b0, wuser_m)
    `CHK("buser tied", 1'b0, buser_s)
  endtask
  task summarize;
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_flow;
    t_mask;
    t_ctl;
    summarize;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    miscompares++;
    summarize;
  end
endmodule
